/* File: hw/rtlc_map.svh */
`ifndef RTLC_MAP_SVH
`define RTLC_MAP_SVH

// Default primary bus address and the highest address that may be set.
`define RTLC_ADDR_DEFAULT 5'h10
`define RTLC_ADDR_MAX     5'h1E

// Command byte encodings presented on the decoded command port.
`define RTLC_CMD_GTL 8'h01
`define RTLC_CMD_SDC 8'h04
`define RTLC_CMD_GET 8'h08
`define RTLC_CMD_LLO 8'h11
`define RTLC_CMD_DCL 8'h14
`define RTLC_CMD_SPE 8'h18
`define RTLC_CMD_SPD 8'h19
`define RTLC_CMD_UNL 8'h3F
`define RTLC_CMD_UNT 8'h5F

// Address group bases: listen addresses start at 0x20, talk at 0x40.
`define RTLC_LAG_BASE 3'h1
`define RTLC_TAG_BASE 3'h2

// Key mask bit positions.
`define RTLC_KEY_LOCAL 0
`define RTLC_KEY_OUTOFF 1
`define RTLC_KEY_FRONT_TRIGGER 2
`define RTLC_KEY_W 8

`endif

/* File: hw/rtlc_pkg.sv */
package rtlc_pkg;

  typedef enum logic [1:0]
  {
    RTLC_LOCS,
    RTLC_REMS,
    RTLC_RWLS,
    RTLC_LWLS
  } rtlc_rl_type;

  // Bus-side interface clear and remote enable levels, a one-cycle command strobe, plus the command byte.
  typedef struct packed {
    logic       ifc;
    logic       ren;
    logic       cmd_valid;
    logic [7:0] cmd;
  } rtlc_bus_type;

  // Requests to the message layer, each a one-cycle pulse.
  typedef struct packed {
    logic dev_clear;
    logic trigger;
    logic status_read;
  } rtlc_act_type;

endpackage

/* File: hw/rtlc_ctrl.sv */
// Overview of operation
// (R01) Remote is entered only on own listen address while remote enable holds.
// (R02) Interface clear forces local, talker idle and listener idle.
// (R03) Interface clear touches no settings, data or event registers.
// (R04) Controller holds interface clear at least 100 us.
// (R05) Lockout disables all keys but output-off; local key is ignored.
// (R06) Go-to-local or power-up reset cancels lockout.
// (R07) Go-to-local in remote returns to local and enables keys.
// (R08) Device clear empties buffers, cancels deferred and blocking commands.
// (R09) Device clear keeps settings and stored data.
// (R10) Universal clear always acts; selective clear only while addressed.
// (R11) Group trigger fires a trigger only when the source is bus.
// (R12) Serial poll returns the status byte at any time.
// (R13) Remote locks all keys but local; remote indicator equals remote.
// (R14) Manual trigger source keeps the trigger key live in remote.
// (R15) Own talk address enters talker active; talk indicator follows.
// (R16) Untalk, listen addressing or interface clear makes talker idle.
// (R17) Own listen address enters listener active; listen indicator follows.
// (R18) Unlisten, talk addressing or interface clear makes listener idle.
// (R19) Service request stays until the poll byte is read or causes clear.
// (R20) Local key cancels remote unless lockout is in effect.
// (R21) Addresses compare with a primary address 0 to 30, default 16.
// (R22) Remote enable going false returns to local and clears lockout.
`timescale 1ns/1ps
`default_nettype none
`include "rtlc_map.svh"

module rtlc_ctrl
  import rtlc_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_ce,
  input  wire rtlc_bus_type           i_bus,
  input  wire logic [4:0]             i_my_addr,
  input  wire logic                   i_trigger_src_bus,
  input  wire logic                   i_trigger_src_manual,
  input  wire logic [`RTLC_KEY_W-1:0] i_keys,
  input  wire logic                   i_srq_cause,
  input  wire logic [7:0]             i_status_byte,
  output rtlc_act_type                o_act,
  output logic [`RTLC_KEY_W-1:0]      o_keys,
  output logic                        o_remote_indicator,
  output logic                        o_lockout,
  output logic                        o_talk_indicator,
  output logic                        o_listen_indicator,
  output logic                        o_srq,
  output logic                        o_spoll_active,
  output logic [7:0]                  o_spoll_byte,
  output logic [4:0]                  o_addr_used
);

  rtlc_rl_type rl_state;
  rtlc_rl_type next_rl_state;
  logic        talk_act;
  logic        listen_act;
  logic        spoll_mode;
  logic        srq_held;
  logic        cause_q;
  logic [4:0]  addr;
  logic        cmd;
  logic        is_mla;
  logic        is_mta;
  logic        is_lag;
  logic        is_tag;
  logic        local_press;
  logic        is_remote;
  logic        is_lockout;

  // Out-of-range settings fall back to the default address.
  assign addr = (i_my_addr > `RTLC_ADDR_MAX) ? `RTLC_ADDR_DEFAULT
                                             : i_my_addr;  // [R21]
  assign cmd = i_ce & i_bus.cmd_valid;
  assign is_lag = cmd & (i_bus.cmd[7:5] == `RTLC_LAG_BASE)
                  & (i_bus.cmd != `RTLC_CMD_UNL);
  assign is_tag = cmd & (i_bus.cmd[7:5] == `RTLC_TAG_BASE)
                  & (i_bus.cmd != `RTLC_CMD_UNT);
  assign is_mla = is_lag & (i_bus.cmd[4:0] == addr);  // [R21]
  assign is_mta = is_tag & (i_bus.cmd[4:0] == addr);
  assign local_press = i_keys[`RTLC_KEY_LOCAL];
  assign is_remote = (rl_state == RTLC_REMS) || (rl_state == RTLC_RWLS);
  assign is_lockout = (rl_state == RTLC_RWLS) || (rl_state == RTLC_LWLS);

  always_comb
  begin
    next_rl_state = rl_state;
    if (!i_bus.ren)
      next_rl_state = RTLC_LOCS;  // [R22]
    else if (i_bus.ifc)
      next_rl_state = is_lockout ? RTLC_LWLS : RTLC_LOCS;  // [R02]
    else if (cmd && i_bus.cmd == `RTLC_CMD_GTL && listen_act)
      next_rl_state = RTLC_LOCS;  // [R06] [R07]
    else
    begin
      unique case (rl_state)
        RTLC_LOCS:
          if (is_mla)
            next_rl_state = RTLC_REMS;  // [R01]
          else if (cmd && i_bus.cmd == `RTLC_CMD_LLO)
            next_rl_state = RTLC_LWLS;
        RTLC_REMS:
          if (cmd && i_bus.cmd == `RTLC_CMD_LLO)
            next_rl_state = RTLC_RWLS;  // [R05]
          else if (i_ce && local_press)
            next_rl_state = RTLC_LOCS;  // [R20]
        RTLC_LWLS:
          if (is_mla)
            next_rl_state = RTLC_RWLS;  // [R01]
        RTLC_RWLS:
          next_rl_state = RTLC_RWLS;  // [R05] [R20]
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      rl_state <= RTLC_LOCS;  // [R06]
    else if (i_ce)
      rl_state <= next_rl_state;
  end

  // Talker and listener are mutually exclusive in this device.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      talk_act   <= 1'b0;
      listen_act <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_bus.ifc)
      begin
        talk_act   <= 1'b0;  // [R02] [R16]
        listen_act <= 1'b0;  // [R02] [R18]
      end
      else if (cmd)
      begin
        if (is_mta)
          talk_act <= 1'b1;  // [R15]
        else if (i_bus.cmd == `RTLC_CMD_UNT || is_mla)
          talk_act <= 1'b0;  // [R16]
        if (is_mla)
          listen_act <= 1'b1;  // [R17]
        else if (i_bus.cmd == `RTLC_CMD_UNL || is_mta)
          listen_act <= 1'b0;  // [R18]
      end
    end
  end

  // Serial poll mode and the held request; the status byte is registered every enabled cycle.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      spoll_mode   <= 1'b0;
      o_spoll_byte <= 8'h00;
      srq_held     <= 1'b0;
      cause_q      <= 1'b0;
    end
    else if (i_ce)
    begin
      // Interface clear ends a poll but keeps the held request and status.
      if (i_bus.ifc)
        spoll_mode <= 1'b0;  // [R03]
      else if (cmd && i_bus.cmd == `RTLC_CMD_SPE)
        spoll_mode <= 1'b1;  // [R12]
      else if (cmd && i_bus.cmd == `RTLC_CMD_SPD)
        spoll_mode <= 1'b0;
      // Bit 6 of the returned byte carries the held service request.
      o_spoll_byte <= i_status_byte | {1'b0, srq_held, 6'h00};  // [R12]
      cause_q      <= i_srq_cause;
      // Only a new cause raises the request, so a cause that is still
      // present after the poll read does not raise it again. A new cause
      // wins over the read that would clear the request.
      if (i_srq_cause && !cause_q)
        srq_held <= 1'b1;  // [R19]
      else if (!i_srq_cause)
        srq_held <= 1'b0;  // [R19]
      else if (spoll_mode && talk_act && cmd
               && i_bus.cmd == `RTLC_CMD_SPD)
        srq_held <= 1'b0;  // [R19]
    end
  end

  // Action pulses; settings and stored data are never touched here.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      o_act <= '0;
    else if (i_ce)
    begin
      o_act.dev_clear <= cmd && (i_bus.cmd == `RTLC_CMD_DCL
                         || (i_bus.cmd == `RTLC_CMD_SDC
                             && listen_act));  // [R08] [R09] [R10]
      o_act.trigger <= cmd && i_bus.cmd == `RTLC_CMD_GET && listen_act
                       && i_trigger_src_bus;  // [R11]
      o_act.status_read <= spoll_mode && talk_act && cmd
                           && i_bus.cmd == `RTLC_CMD_SPD;  // [R12]
    end
    else
      o_act <= '0;
  end

  // Key gating follows the remote and lockout states.
  always_comb
  begin
    o_keys = i_keys;
    if (is_remote)
    begin
      o_keys = '0;  // [R13]
      o_keys[`RTLC_KEY_LOCAL] = i_keys[`RTLC_KEY_LOCAL] & ~is_lockout;
      o_keys[`RTLC_KEY_FRONT_TRIGGER] = i_keys[`RTLC_KEY_FRONT_TRIGGER]
                                        & i_trigger_src_manual;  // [R14]
    end
    if (is_lockout)
    begin
      o_keys = '0;  // [R05]
      o_keys[`RTLC_KEY_OUTOFF] = i_keys[`RTLC_KEY_OUTOFF];
      if (is_remote)
        o_keys[`RTLC_KEY_FRONT_TRIGGER] = i_keys[`RTLC_KEY_FRONT_TRIGGER]
                                          & i_trigger_src_manual;  // [R14]
    end
  end

  assign o_remote_indicator = is_remote;  // [R13]
  assign o_lockout          = is_lockout;
  assign o_talk_indicator   = talk_act;  // [R15]
  assign o_listen_indicator = listen_act;  // [R17]
  assign o_srq              = srq_held;  // [R19]
  assign o_spoll_active     = spoll_mode;
  assign o_addr_used        = addr;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_ren_only;
    i_ce && i_bus.ren && !i_bus.ifc && !is_mla && !cmd;
  endsequence

  // A poll read is the disable command taken while polled and talking.
  sequence s_poll_read;
    spoll_mode && talk_act && cmd && i_bus.cmd == `RTLC_CMD_SPD;
  endsequence

  a_ren_alone_local: assert property (  // [R01]
    (rl_state == RTLC_LOCS) and s_ren_only |=> rl_state == RTLC_LOCS)
    else $error("remote entered without listen address");

  a_mla_remote: assert property (  // [R01]
    i_ce && i_bus.ren && !i_bus.ifc && is_mla && !is_lockout
    && !local_press |=> o_remote_indicator)
    else $error("listen address under ren did not set remote");

  a_ifc_idle: assert property (  // [R02]
    i_ce && i_bus.ifc |=> !o_talk_indicator && !o_listen_indicator
                          && !o_remote_indicator)
    else $error("ifc did not idle talker and listener");

  a_lockout_keys: assert property (  // [R05]
    is_lockout |-> o_keys[`RTLC_KEY_LOCAL] == 1'b0
                   && o_keys[`RTLC_KEY_OUTOFF] == i_keys[`RTLC_KEY_OUTOFF])
    else $error("lockout key gating wrong");

  a_ren_drop_local: assert property (  // [R22]
    i_ce && !i_bus.ren |=> rl_state == RTLC_LOCS)
    else $error("ren false did not return local");

  a_sdc_addressed: assert property (  // [R10]
    cmd && i_bus.cmd == `RTLC_CMD_SDC && !listen_act
    |=> !o_act.dev_clear)
    else $error("sdc acted while unaddressed");

  a_dcl_always: assert property (  // [R08]
    cmd && i_bus.cmd == `RTLC_CMD_DCL |=> o_act.dev_clear)
    else $error("dcl ignored");

  a_get_source: assert property (  // [R11]
    o_act.trigger |-> $past(i_trigger_src_bus) && $past(listen_act))
    else $error("trigger without bus source");

  a_mta_talk: assert property (  // [R15]
    is_mta && !i_bus.ifc |=> o_talk_indicator && !o_listen_indicator)
    else $error("own talk address ignored");

  a_srq_hold: assert property (  // [R19]
    o_srq && i_ce && i_srq_cause && !(cmd && i_bus.cmd == `RTLC_CMD_SPD)
    |=> o_srq)
    else $error("service request dropped early");

  a_ifc_no_action: assert property (  // [R03]
    i_ce && i_bus.ifc && !cmd
    |=> !o_act.dev_clear && !o_act.trigger)
    else $error("interface clear started a clear or trigger");

  a_llo_lock: assert property (  // [R05]
    cmd && i_bus.cmd == `RTLC_CMD_LLO && i_bus.ren && !i_bus.ifc
    |=> o_lockout)
    else $error("lockout command ignored");

  a_gtl_local: assert property (  // [R07]
    cmd && i_bus.cmd == `RTLC_CMD_GTL && listen_act && i_bus.ren
    && !i_bus.ifc |=> !o_remote_indicator && !o_lockout)
    else $error("go to local did not restore local");

  a_remote_keys: assert property (  // [R13]
    is_remote && !is_lockout |-> o_keys[`RTLC_KEY_OUTOFF] == 1'b0
    && o_keys[`RTLC_KEY_LOCAL] == i_keys[`RTLC_KEY_LOCAL])
    else $error("remote key gating wrong");

  a_manual_trigger: assert property (  // [R14]
    is_remote |-> o_keys[`RTLC_KEY_FRONT_TRIGGER]
    == (i_keys[`RTLC_KEY_FRONT_TRIGGER] & i_trigger_src_manual))
    else $error("trigger key gating wrong in remote");

  a_local_key: assert property (  // [R20]
    rl_state == RTLC_REMS && i_ce && i_bus.ren && !i_bus.ifc && !cmd
    && local_press |=> !o_remote_indicator)
    else $error("local key did not cancel remote");

  a_lockout_local_key: assert property (  // [R20]
    rl_state == RTLC_RWLS && i_ce && i_bus.ren && !i_bus.ifc && !cmd
    |=> o_remote_indicator)
    else $error("remote left while lockout held");

  a_mla_listen: assert property (  // [R17]
    is_mla && !i_bus.ifc |=> o_listen_indicator && !o_talk_indicator)
    else $error("own listen address ignored");

  a_unl_idle: assert property (  // [R18]
    cmd && i_bus.cmd == `RTLC_CMD_UNL |=> !o_listen_indicator)
    else $error("unlisten left listener active");

  a_unt_idle: assert property (  // [R16]
    cmd && i_bus.cmd == `RTLC_CMD_UNT |=> !o_talk_indicator)
    else $error("untalk left talker active");

  a_poll_read: assert property (  // [R12]
    s_poll_read |=> o_act.status_read && !o_spoll_active)
    else $error("poll read not reported");

  a_srq_read_clear: assert property (  // [R19]
    cause_q and s_poll_read |=> !o_srq)
    else $error("service request survived the poll read");

  a_srq_cause_gone: assert property (  // [R19]
    i_ce && !i_srq_cause |=> !o_srq)
    else $error("service request stayed without a cause");

endmodule
`default_nettype wire

/* File: bench/rtlc_ctlr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtlc_ctlr_model
  import rtlc_pkg::*;
#(
  parameter int IFC_CYC = 12500
)
(
  input  wire logic   i_mclk,
  output var rtlc_bus_type o_bus
);
  initial o_bus = '0;

  // The byte is inverted once released so no stale value lingers.
  task automatic send(input logic [7:0] c);
    @(posedge i_mclk);
    o_bus.cmd_valid <= 1'b1;
    o_bus.cmd       <= c;
    @(posedge i_mclk);
    o_bus.cmd_valid <= 1'b0;
    o_bus.cmd       <= ~c;
  endtask

  task automatic ren(input logic v);
    @(posedge i_mclk);
    o_bus.ren <= v;
  endtask

  task automatic ifc();
    @(posedge i_mclk);
    o_bus.ifc <= 1'b1;
    repeat (IFC_CYC) @(posedge i_mclk);
    o_bus.ifc <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/ieee488_remote_talk_listen_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ieee488_remote_talk_listen_control_tb_top;
  import rtlc_pkg::*;
  logic         mclk;
  logic         rstn;
  logic         ce;
  rtlc_bus_type bus;
  logic [4:0]   my_addr;
  logic         tsb;
  logic         tsm;
  logic [7:0]   keys;
  logic         cause;
  logic [7:0]   sbyte;
  rtlc_act_type act;
  logic [7:0]   okeys;
  logic         remote;
  logic         lock;
  logic         talk;
  logic         listen;
  logic         srq;
  logic         spa;
  logic [7:0]   spb;
  logic [4:0]   addr;
  int           n_fail;
  int           cmp_count;

  rtlc_ctlr_model m (.i_mclk(mclk), .o_bus(bus));

  rtlc_ctrl dut (
    .i_mclk(mclk), .i_rstn(rstn), .i_ce(ce), .i_bus(bus),
    .i_my_addr(my_addr), .i_trigger_src_bus(tsb), .i_trigger_src_manual(tsm),
    .i_keys(keys), .i_srq_cause(cause), .i_status_byte(sbyte),
    .o_act(act), .o_keys(okeys), .o_remote_indicator(remote),
    .o_lockout(lock), .o_talk_indicator(talk), .o_listen_indicator(listen),
    .o_srq(srq), .o_spoll_active(spa), .o_spoll_byte(spb),
    .o_addr_used(addr)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    m.send(c);
    #1;
  endtask

  task automatic drive(input logic [7:0] k, input logic mn, input logic b);
    @(posedge mclk);
    keys <= k;
    tsm  <= mn;
    tsb  <= b;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    my_addr = 5'h1F;
    tsb = 1'b0;
    tsm = 1'b0;
    keys = 8'h00;
    cause = 1'b0;
    sbyte = 8'h05;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk("remote", 8'h00, remote);
    chk("addr", 8'h10, addr);
    m.ren(1'b1);
    drive(8'h00, 1'b0, 1'b0);
    chk("remote", 8'h00, remote);
    cmd(8'h30);
    chk("remote", 8'h01, remote);
    chk("listen", 8'h01, listen);
    drive(8'hFE, 1'b0, 1'b0);
    chk("keys", 8'h00, okeys);
    drive(8'hFE, 1'b1, 1'b0);
    chk("keys", 8'h04, okeys);
    cmd(8'h14);
    chk("clear", 8'h01, act.dev_clear);
    cmd(8'h3F);
    chk("listen", 8'h00, listen);
    cmd(8'h04);
    chk("clear", 8'h00, act.dev_clear);
    cmd(8'h30);
    cmd(8'h04);
    chk("clear", 8'h01, act.dev_clear);
    cmd(8'h08);
    chk("trigger", 8'h00, act.trigger);
    drive(8'h00, 1'b0, 1'b1);
    cmd(8'h08);
    chk("trigger", 8'h01, act.trigger);
    cmd(8'h50);
    chk("talk", 8'h01, talk);
    chk("listen", 8'h00, listen);
    cmd(8'h30);
    chk("talk", 8'h00, talk);
    cmd(8'h50);
    cmd(8'h5F);
    chk("talk", 8'h00, talk);
    drive(8'h01, 1'b0, 1'b1);
    chk("remote", 8'h00, remote);
    drive(8'h00, 1'b0, 1'b1);
    cmd(8'h30);
    cmd(8'h11);
    chk("lockout", 8'h01, lock);
    drive(8'hFF, 1'b0, 1'b1);
    chk("keys", 8'h02, okeys);
    drive(8'h01, 1'b0, 1'b1);
    chk("remote", 8'h01, remote);
    cmd(8'h01);
    chk("remote", 8'h00, remote);
    chk("lockout", 8'h00, lock);
    drive(8'hFF, 1'b0, 1'b1);
    chk("keys", 8'hFF, okeys);
    drive(8'h00, 1'b0, 1'b1);
    cmd(8'h30);
    cmd(8'h11);
    cmd(8'h50);
    m.ifc();
    #1;
    chk("remote", 8'h00, remote);
    chk("talk", 8'h00, talk);
    chk("listen", 8'h00, listen);
    chk("lockout", 8'h01, lock);
    m.ren(1'b0);
    drive(8'h00, 1'b0, 1'b1);
    chk("lockout", 8'h00, lock);
    @(posedge mclk);
    cause <= 1'b1;
    drive(8'h00, 1'b0, 1'b1);
    chk("srq", 8'h01, srq);
    cmd(8'h18);
    chk("poll", 8'h01, spa);
    cmd(8'h50);
    chk("byte", 8'h45, spb);
    cmd(8'h19);
    chk("read", 8'h01, act.status_read);
    @(posedge mclk);
    #1;
    chk("srq", 8'h00, srq);
    @(posedge mclk);
    my_addr <= 5'h03;
    cmd(8'h23);
    chk("addr", 8'h03, addr);
    chk("listen", 8'h01, listen);
    tally_and_finish();
  end
endmodule
`default_nettype wire
